// File: hw/ais_pkg.sv
package ais_pkg;

  // Register indices; the byte address on the bus is four times the index.
  localparam logic [5:0] IDX_CTRL_A  = 6'h00;
  localparam logic [5:0] IDX_COMMAND = 6'h0a;
  localparam logic [5:0] IDX_AMP     = 6'h0b;
  localparam logic [5:0] IDX_POS     = 6'h0c;
  localparam logic [5:0] IDX_NEG     = 6'h0d;
  localparam logic [5:0] IDX_RESULT  = 6'h10;
  localparam logic [5:0] IDX_SAMPLE  = 6'h14;

  // Reset values.
  localparam logic [7:0]  CTRL_A_RST  = 8'h00;
  localparam logic [7:0]  COMMAND_RST = 8'h00;
  localparam logic [7:0]  AMP_RST     = 8'h04;
  localparam logic [7:0]  SEL_RST     = 8'h00;
  localparam logic [31:0] RESULT_RST  = 32'h0000_0000;
  localparam logic [15:0] SAMPLE_RST  = 16'h0000;

  // Field positions.
  localparam int LOW_LAT_BIT = 0;
  localparam int DIFFERENTIAL_SELECT_BIT    = 7;
  localparam int START_HI    = 2;
  localparam int START_LO    = 0;
  localparam int GAIN_HI     = 7;
  localparam int GAIN_LO     = 5;
  localparam int BIAS_HI     = 4;
  localparam int BIAS_LO     = 3;
  localparam int DUR_HI      = 2;
  localparam int DUR_LO      = 1;
  localparam int AMP_EN_BIT  = 0;
  localparam int VIA_HI      = 7;
  localparam int VIA_LO      = 6;
  localparam int SEL_HI      = 5;
  localparam int SEL_LO      = 0;

  // Field codes.
  localparam logic [2:0] START_POS_WRITE = 3'h2;
  localparam logic [2:0] START_NEG_WRITE = 3'h3;
  localparam logic [1:0] VIA_DIRECT      = 2'h0;
  localparam logic [1:0] VIA_AMP         = 2'h1;
  localparam logic [1:0] DUR_CODE_A      = 2'h0;
  localparam logic [1:0] DUR_CODE_B      = 2'h1;
  localparam logic [1:0] DUR_CODE_C      = 2'h2;
  localparam logic [5:0] SEL_DEFAULT     = 6'h00;
  localparam logic [5:0] SEL_GND         = 6'h30;
  localparam logic [5:0] SEL_SUPPLY      = 6'h31;
  localparam logic [5:0] SEL_TEMP        = 6'h32;
  localparam logic [5:0] SEL_CREF        = 6'h33;
  localparam logic [3:0] POS_MAX_PIN     = 4'hf;
  localparam logic [3:0] NEG_MAX_PIN     = 4'h7;

  // Amplifier sampling durations in converter clock cycles.
  localparam logic [4:0] AMP_CYC_A    = 5'h06;
  localparam logic [4:0] AMP_CYC_B    = 5'h0f;
  localparam logic [4:0] AMP_CYC_C    = 5'h14;
  localparam logic [4:0] AMP_CYC_RSVD = 5'h14;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    SRC_GND    = 3'h0,
    SRC_PIN    = 3'h1,
    SRC_SUPPLY = 3'h2,
    SRC_TEMP   = 3'h3,
    SRC_CREF   = 3'h4,
    SRC_RSVD   = 3'h7
  } ais_src_t;

endpackage

// File: hw/ais_decode.sv
`timescale 1ns/1ps
module ais_decode
  import ais_pkg::*;
#(
  parameter logic [3:0] MAX_PIN    = 4'hf,
  parameter bit         ALLOW_TEMP = 1'b1
) (
  input  wire logic [5:0] sel,
  output ais_src_t        src,
  output logic [3:0]      pin
);

  always_comb begin
    src = SRC_RSVD;
    pin = 4'h0;
    if (sel == SEL_DEFAULT) begin
      src = SRC_GND;
    end else if (sel <= {2'h0, MAX_PIN}) begin
      src = SRC_PIN;
      pin = sel[3:0];
    end else begin
      case (sel)
        SEL_GND:    src = SRC_GND;
        SEL_SUPPLY: src = SRC_SUPPLY;
        SEL_TEMP:   src = ALLOW_TEMP ? SRC_TEMP : SRC_RSVD;
        SEL_CREF:   src = SRC_CREF;
        default:    src = SRC_RSVD;
      endcase
    end
  end

endmodule

// File: hw/ais_amp.sv
`timescale 1ns/1ps
module ais_amp
  import ais_pkg::*;
(
  input  wire logic [1:0] dur_code,
  input  wire logic       amp_enable,
  input  wire logic       low_latency,
  input  wire logic [1:0] via,
  output logic [4:0]      cycles,
  output logic            power,
  output logic            route
);

  always_comb begin
    case (dur_code)
      DUR_CODE_A: cycles = AMP_CYC_A;
      DUR_CODE_B: cycles = AMP_CYC_B;
      DUR_CODE_C: cycles = AMP_CYC_C;
      // The reserved code keeps the longest, safest duration.
      default:    cycles = AMP_CYC_RSVD;
    endcase
  end

  // Low latency keeps the amplifier biased while amp_enable is set, so that a later switch to the
  // amplifier path needs no warm-up.
  always_comb begin
    route = (via == VIA_AMP);
    power = amp_enable && ((via == VIA_AMP) || low_latency);
  end

endmodule

// File: hw/ais_top.sv
// The AXI4-Lite register port was decided locally.
`timescale 1ns/1ps
module ais_top
  import ais_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        sample_valid,
  input  wire logic [15:0] sample_data,
  input  wire logic        result_valid,
  input  wire logic [31:0] result_data,
  output ais_src_t         pos_src,
  output logic [3:0]       pos_pin,
  output ais_src_t         neg_src,
  output logic [3:0]       neg_pin,
  output logic             neg_used,
  output logic             amp_route,
  output logic             amp_power,
  output logic [2:0]       amp_gain,
  output logic [1:0]       amp_bias,
  output logic [4:0]       amp_sample_cycles,
  output logic             conv_start
);

  logic        awready_q;
  logic        wready_q;
  logic        bvalid_q;
  logic [1:0]  bresp_q;
  logic [5:0]  aw_idx_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;
  logic        arready_q;
  logic        rvalid_q;
  logic [1:0]  rresp_q;
  logic [31:0] rdata_q;
  logic        wr_fire;
  logic        wr_lane0;
  logic [7:0]  ctrl_a_q;
  logic [7:0]  command_q;
  logic [7:0]  amp_q;
  logic [1:0]  via_q;
  logic [5:0]  pos_sel_q;
  logic [5:0]  neg_sel_q;
  logic [31:0] result_q;
  logic [15:0] sample_q;
  logic        conv_start_q;
  ais_src_t    pos_src_w;
  ais_src_t    neg_src_w;
  logic [3:0]  pos_pin_w;
  logic [3:0]  neg_pin_w;
  logic [4:0]  cycles_w;
  logic        power_w;
  logic        route_w;
  ais_src_t    pos_src_q;
  ais_src_t    neg_src_q;
  logic [3:0]  pos_pin_q;
  logic [3:0]  neg_pin_q;
  logic        neg_used_q;
  logic        amp_route_q;
  logic        amp_power_q;
  logic [4:0]  amp_cycles_q;

  // A write fires once address and data are held and no response waits.
  assign wr_fire  = !awready_q && !wready_q && !bvalid_q;
  assign wr_lane0 = wr_fire && w_strb_q[0];

  function automatic logic mapped(input logic [5:0] idx);
    mapped = (idx == IDX_CTRL_A) || (idx == IDX_COMMAND) ||
             (idx == IDX_AMP) || (idx == IDX_POS) || (idx == IDX_NEG) ||
             (idx == IDX_RESULT) || (idx == IDX_SAMPLE);
  endfunction

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      awready_q <= 1'b1;
      aw_idx_q  <= 6'h00;
    end else if (s_axi_awvalid && awready_q) begin
      awready_q <= 1'b0;
      aw_idx_q  <= s_axi_awaddr[7:2];
    end else if (wr_fire) begin
      awready_q <= 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      wready_q <= 1'b1;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
    end else if (s_axi_wvalid && wready_q) begin
      wready_q <= 1'b0;
      w_data_q <= s_axi_wdata;
      w_strb_q <= s_axi_wstrb;
    end else if (wr_fire) begin
      wready_q <= 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      bresp_q  <= mapped(aw_idx_q) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ctrl_a_q  <= CTRL_A_RST;
      command_q <= COMMAND_RST;
      amp_q     <= AMP_RST;
    end else if (wr_lane0) begin
      if (aw_idx_q == IDX_CTRL_A) begin
        ctrl_a_q <= w_data_q[7:0];
      end
      if (aw_idx_q == IDX_COMMAND) begin
        command_q <= w_data_q[7:0];
      end
      if (aw_idx_q == IDX_AMP) begin
        amp_q <= w_data_q[7:0];
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      via_q     <= SEL_RST[VIA_HI:VIA_LO];
      pos_sel_q <= SEL_RST[SEL_HI:SEL_LO];
      neg_sel_q <= SEL_RST[SEL_HI:SEL_LO];
    end else if (wr_lane0) begin
      if (aw_idx_q == IDX_POS) begin
        via_q     <= w_data_q[VIA_HI:VIA_LO];
        pos_sel_q <= w_data_q[SEL_HI:SEL_LO];
      end
      if (aw_idx_q == IDX_NEG) begin
        via_q     <= w_data_q[VIA_HI:VIA_LO];
        neg_sel_q <= w_data_q[SEL_HI:SEL_LO];
      end
    end
  end

  // Bus writes never reach result or sample, so none corrupts a reading.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      result_q <= RESULT_RST;
      sample_q <= SAMPLE_RST;
    end else begin
      if (result_valid) begin
        result_q <= result_data;
      end
      if (sample_valid) begin
        sample_q <= sample_data;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      conv_start_q <= 1'b0;
    end else begin
      conv_start_q <= wr_lane0 &&
        (((aw_idx_q == IDX_POS) &&
          (command_q[START_HI:START_LO] == START_POS_WRITE)) ||
         ((aw_idx_q == IDX_NEG) &&
          (command_q[START_HI:START_LO] == START_NEG_WRITE)));
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rresp_q   <= RESP_OKAY;
      rdata_q   <= 32'h0000_0000;
    end else if (s_axi_arvalid && arready_q) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b1;
      rresp_q   <= mapped(s_axi_araddr[7:2]) ? RESP_OKAY : RESP_SLVERR;
      case (s_axi_araddr[7:2])
        IDX_CTRL_A:  rdata_q <= {24'h000000, ctrl_a_q};
        IDX_COMMAND: rdata_q <= {24'h000000, command_q};
        IDX_AMP:     rdata_q <= {24'h000000, amp_q};
        IDX_POS:     rdata_q <= {24'h000000, via_q, pos_sel_q};
        IDX_NEG:     rdata_q <= {24'h000000, via_q, neg_sel_q};
        IDX_RESULT:  rdata_q <= result_q;
        IDX_SAMPLE:  rdata_q <= {16'h0000, sample_q};
        default:     rdata_q <= 32'h0000_0000;
      endcase
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q  <= 1'b0;
      arready_q <= 1'b1;
    end
  end

  ais_decode #(
    .MAX_PIN    (POS_MAX_PIN),
    .ALLOW_TEMP (1'b1)
  ) u_pos_decode (
    .sel (pos_sel_q),
    .src (pos_src_w),
    .pin (pos_pin_w)
  );
  ais_decode #(
    .MAX_PIN    (NEG_MAX_PIN),
    .ALLOW_TEMP (1'b0)
  ) u_neg_decode (
    .sel (neg_sel_q),
    .src (neg_src_w),
    .pin (neg_pin_w)
  );
  ais_amp u_amp (
    .dur_code    (amp_q[DUR_HI:DUR_LO]),
    .amp_enable  (amp_q[AMP_EN_BIT]),
    .low_latency (ctrl_a_q[LOW_LAT_BIT]),
    .via         (via_q),
    .cycles      (cycles_w),
    .power       (power_w),
    .route       (route_w)
  );

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pos_src_q    <= SRC_GND;
      pos_pin_q    <= 4'h0;
      neg_src_q    <= SRC_GND;
      neg_pin_q    <= 4'h0;
      neg_used_q   <= 1'b0;
      amp_route_q  <= 1'b0;
      amp_power_q  <= 1'b0;
      amp_cycles_q <= AMP_CYC_C;
    end else begin
      pos_src_q    <= pos_src_w;
      pos_pin_q    <= pos_pin_w;
      neg_src_q    <= neg_src_w;
      neg_pin_q    <= neg_pin_w;
      neg_used_q   <= command_q[DIFFERENTIAL_SELECT_BIT];
      amp_route_q  <= route_w;
      amp_power_q  <= power_w;
      amp_cycles_q <= cycles_w;
    end
  end

  assign s_axi_awready     = awready_q;
  assign s_axi_wready      = wready_q;
  assign s_axi_bvalid      = bvalid_q;
  assign s_axi_bresp       = bresp_q;
  assign s_axi_arready     = arready_q;
  assign s_axi_rvalid      = rvalid_q;
  assign s_axi_rresp       = rresp_q;
  assign s_axi_rdata       = rdata_q;
  assign pos_src           = pos_src_q;
  assign pos_pin           = pos_pin_q;
  assign neg_src           = neg_src_q;
  assign neg_pin           = neg_pin_q;
  assign neg_used          = neg_used_q;
  assign amp_route         = amp_route_q;
  assign amp_power         = amp_power_q;
  assign amp_gain          = amp_q[GAIN_HI:GAIN_LO];
  assign amp_bias          = amp_q[BIAS_HI:BIAS_LO];
  assign amp_sample_cycles = amp_cycles_q;
  assign conv_start        = conv_start_q;

  a_dur_fifteen: assert property (@(posedge mclk) disable iff (!rst_n)
    (amp_q[DUR_HI:DUR_LO] == DUR_CODE_B) |=> (amp_sample_cycles == 5'h0f))
    else $error("sample duration not fifteen cycles");
  a_amp_selected: assert property (@(posedge mclk) disable iff (!rst_n)
    (amp_q[AMP_EN_BIT] && (via_q == VIA_AMP)) |=> amp_power)
    else $error("amplifier off while enabled and routed");
  a_amp_low_latency: assert property (@(posedge mclk) disable iff (!rst_n)
    (amp_q[AMP_EN_BIT] && ctrl_a_q[LOW_LAT_BIT]) |=> amp_power)
    else $error("amplifier off in low latency");
  a_amp_idle: assert property (@(posedge mclk) disable iff (!rst_n)
    (!amp_q[AMP_EN_BIT] || ((via_q == VIA_DIRECT) &&
      !ctrl_a_q[LOW_LAT_BIT])) |=> !amp_power)
    else $error("amplifier on without cause");
  a_route_direct: assert property (@(posedge mclk) disable iff (!rst_n)
    (via_q == VIA_DIRECT) |=> !amp_route)
    else $error("routing through amplifier on direct code");
  a_via_shared: assert property (@(posedge mclk) disable iff (!rst_n)
    (wr_lane0 && (aw_idx_q == IDX_NEG)) |=>
      ##1 (amp_route == ($past(w_data_q[VIA_HI:VIA_LO], 2) == VIA_AMP)))
    else $error("negative write did not steer shared routing");
  a_pos_pin: assert property (@(posedge mclk) disable iff (!rst_n)
    ((pos_sel_q != 6'h00) && (pos_sel_q <= 6'h0f)) |=>
      ((pos_src == SRC_PIN) && (pos_pin == $past(pos_sel_q[3:0]))))
    else $error("positive pin code misdecoded");
  a_neg_temp: assert property (@(posedge mclk) disable iff (!rst_n)
    (neg_sel_q == SEL_TEMP) || (neg_sel_q == 6'h08) |=>
      (neg_src == SRC_RSVD))
    else $error("negative reserved code accepted");
  a_result_hold: assert property (@(posedge mclk) disable iff (!rst_n)
    (!result_valid && !sample_valid) |=>
      ($stable(result_q) && $stable(sample_q)))
    else $error("read-only register changed without conversion");
  a_start_pulse: assert property (@(posedge mclk) disable iff (!rst_n)
    (wr_lane0 && (aw_idx_q == IDX_POS) &&
     (command_q[START_HI:START_LO] == START_POS_WRITE)) |=>
      conv_start ##1 !conv_start)
    else $error("positive write start not a single pulse");
  a_bresp_hold: assert property (@(posedge mclk) disable iff (!rst_n)
    (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid)
    else $error("write response dropped before acceptance");
endmodule

// File: testbench/ais_conv_model.sv
`timescale 1ns/1ps
module ais_conv_model #(
  parameter int SETTLE = 3
) (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        conv_start,
  input  wire logic [15:0] next_data,
  output logic             sample_valid,
  output logic [15:0]      sample_data,
  output logic             result_valid,
  output logic [31:0]      result_data
);
  int          wait_q;
  logic [31:0] sum_q;

  // Data lines toggle outside a pulse so a stale value is never mistaken
  // for a fresh one.
  always_ff @(posedge mclk) begin
    sample_valid <= 1'b0;
    result_valid <= 1'b0;
    sample_data  <= ~sample_data;
    result_data  <= ~result_data;
    if (!rst_n) begin
      wait_q      <= 0;
      sum_q       <= 32'h0;
      sample_data <= 16'h0;
      result_data <= 32'h0;
    end else if (conv_start) begin
      wait_q <= SETTLE;
    end else if (wait_q == 1) begin
      wait_q       <= 0;
      sample_valid <= 1'b1;
      sample_data  <= next_data;
      sum_q        <= sum_q + 32'(next_data);
    end else if (wait_q > 1) begin
      wait_q <= wait_q - 1;
    end
    if (rst_n && sample_valid) begin
      result_valid <= 1'b1;
      result_data  <= sum_q;
    end
  end
endmodule

// File: testbench/adc_input_select_result_regs_tb.sv
`timescale 1ns/1ps
`define CHK(e, s, n) begin checks++; if ((s) !== (e)) begin failures++; \
  $display("mismatch %s exp %h got %h", n, e, s); end end
module adc_input_select_result_regs_tb
  import ais_pkg::*;
;
  localparam int SETTLE = 3;
  logic        mclk, rst_n, awvalid, awready, wvalid, wready, bvalid;
  logic        bready, arvalid, arready, rvalid, rready, st, bseen;
  logic        svalid, rvld, neg_used, amp_route, amp_power, conv_start;
  logic        rseen;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rres, d, exp_sum;
  logic [3:0]  wstrb, pos_pin, neg_pin;
  logic [1:0]  bresp, rresp, bresp_s, r, amp_bias;
  logic [15:0] sdata, nd;
  logic [2:0]  amp_gain, code;
  logic [4:0]  amp_cyc;
  ais_src_t    pos_src, neg_src;
  int          failures, checks, seed;
  logic [7:0]  ra [6] = '{8'h00, 8'h2c, 8'h30, 8'h34, 8'h40, 8'h50};
  logic [31:0] rv [6] = '{32'h0, 32'h04, 32'h0, 32'h0, 32'h0, 32'h0};

  ais_top dut (
    .mclk(mclk), .rst_n(rst_n),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .sample_valid(svalid), .sample_data(sdata),
    .result_valid(rvld), .result_data(rres),
    .pos_src(pos_src), .pos_pin(pos_pin), .neg_src(neg_src),
    .neg_pin(neg_pin), .neg_used(neg_used), .amp_route(amp_route),
    .amp_power(amp_power), .amp_gain(amp_gain), .amp_bias(amp_bias),
    .amp_sample_cycles(amp_cyc), .conv_start(conv_start)
  );

  ais_conv_model #(.SETTLE(SETTLE)) conv (
    .mclk(mclk), .rst_n(rst_n), .conv_start(conv_start),
    .next_data(nd), .sample_valid(svalid), .sample_data(sdata),
    .result_valid(rvld), .result_data(rres)
  );

  initial mclk = 1'b0;
  always #12.5 mclk = ~mclk;

  function automatic logic [6:0] dec(logic [5:0] c, logic neg);
    if (c == 6'h00 || c == 6'h30) return {SRC_GND, 4'h0};
    if (c <= (neg ? 6'h07 : 6'h0f)) return {SRC_PIN, c[3:0]};
    if (c == 6'h31) return {SRC_SUPPLY, 4'h0};
    if (c == 6'h32 && !neg) return {SRC_TEMP, 4'h0};
    if (c == 6'h33) return {SRC_CREF, 4'h0};
    return {SRC_RSVD, 4'h0};
  endfunction

  function automatic logic [4:0] dur(logic [1:0] c);
    case (c)
      2'h0: return 5'h06;
      2'h1: return 5'h0f;
      default: return 5'h14;
    endcase
  endfunction

  task automatic tick;
    @(posedge mclk);
  endtask

  // Each transfer starts one edge later so no strobe is assigned twice in
  // the same time step.
  task automatic wr(input logic [7:0] a, input logic [31:0] v,
                    input logic [3:0] s);
    @(posedge mclk);
    bseen = 1'b0;
    st = 1'b0;
    awaddr <= a;
    wdata <= v;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!bseen) begin
      @(posedge mclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (conv_start === 1'b1) st = 1'b1;
      if (bvalid === 1'b1) begin
        bseen = 1'b1;
        bresp_s = bresp;
        bready <= 1'b0;
      end
    end
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge mclk);
    rseen = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!rseen) begin
      @(posedge mclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        rseen = 1'b1;
        d = rdata;
        r = rresp;
        rready <= 1'b0;
      end
    end
  endtask

  task automatic done_t(input string n);
    $display("test %s done", n);
  endtask

  task automatic finish_test;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge mclk);
    failures++;
    finish_test;
  end

  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, wdata, wstrb} = 52'h0;
    nd = 16'h0;
    rst_n = 1'b0;
    seed = 32'h888b;
    exp_sum = 32'h0;
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      rd(ra[i]);
      `CHK(rv[i], d, "reset value")
    end
    `CHK(AMP_CYC_C, amp_cyc, "reset cycles")
    `CHK(SRC_GND, pos_src, "reset pos_src")
    rd(8'hfc);
    `CHK(RESP_SLVERR, r, "unmapped rresp")
    wr(8'hfc, 32'h5a, 4'hf);
    `CHK(RESP_SLVERR, bresp_s, "unmapped bresp")
    done_t("reset");
    for (int c = 0; c < 4; c++) begin
      wr(8'h2c, {24'h0, 3'(c), 2'(c), 2'(c), 1'b0}, 4'h1);
      tick;
      `CHK(dur(2'(c)), amp_cyc, "cycles")
      `CHK(3'(c), amp_gain, "amp_gain")
      `CHK(2'(c), amp_bias, "amp_bias")
    end
    done_t("duration");
    for (int k = 0; k < 8; k++) begin
      wr(8'h00, {31'h0, k[0]}, 4'hf);
      wr(8'h2c, {29'h0, 2'h2, k[1]}, 4'h1);
      wr(k[0] ? 8'h34 : 8'h30, {24'h0, 1'b0, k[2], 6'h00}, 4'h1);
      tick;
      `CHK(k[1] & (k[2] | k[0]), amp_power, "amp_power")
      `CHK(k[2], amp_route, "amp_route")
      rd(k[0] ? 8'h30 : 8'h34);
      `CHK({1'b0, k[2]}, d[7:6], "shared routing")
    end
    done_t("amplifier");
    for (int c = 0; c < 64; c++) begin
      wr(8'h30, {26'h0, 6'(c)}, 4'h1);
      wr(8'h34, {26'h0, 6'(c)}, 4'h1);
      tick;
      `CHK(dec(6'(c), 1'b0), {pos_src, pos_pin}, "pos decode")
      `CHK(dec(6'(c), 1'b1), {neg_src, neg_pin}, "neg decode")
    end
    done_t("decode");
    for (int j = 0; j < 6; j++) begin
      code = 3'(j / 2 + 1);
      nd <= 16'($random(seed));
      wr(8'h28, {24'h0, j[1], 4'h0, code}, 4'h1);
      wr(j[0] ? 8'h34 : 8'h30, 32'h01, 4'h1);
      `CHK(code == {2'h1, j[0]}, st, "conv_start")
      tick;
      `CHK(j[1], neg_used, "neg_used")
      if (st) begin
        exp_sum = exp_sum + 32'(nd);
        repeat (SETTLE + 3) tick;
        rd(8'h50);
        `CHK({16'h0, nd}, d, "sample")
        rd(8'h40);
        `CHK(exp_sum, d, "result")
      end
    end
    done_t("start");
    wr(8'h40, 32'hffff_ffff, 4'hf);
    `CHK(RESP_OKAY, bresp_s, "ro bresp")
    wr(8'h50, 32'hffff_ffff, 4'hf);
    rd(8'h40);
    `CHK(exp_sum, d, "result kept")
    rd(8'h50);
    `CHK({16'h0, nd}, d, "sample kept")
    done_t("read only");
    rst_n <= 1'b0;
    repeat (2) tick;
    rst_n <= 1'b1;
    rd(8'h30);
    `CHK(32'h0, d, "pos after reset")
    rd(8'h40);
    `CHK(32'h0, d, "result after reset")
    done_t("second reset");
    finish_test;
  end
endmodule
